// file: rtl/gpio_function_select_mux.sv
// Functional notes
// - Each pin's function comes from the code in its configuration register.
// - Code 0x6E lets the pin input enable fast differential output seven.
// - Code 0x70 ORs pin input with single-ended output zero register enable.
// - Codes 0x72, 0x74, 0x76 do the same for single-ended outputs one to three.
// - Code 0x80 drives the pin high while the interrupt is asserted.
// - Code 0x88 shows reference zero had no toggling in the last second.
// - Code 0x89 shows the single-period check failure of reference zero.
// - Code 0x8A shows the coarse frequency check failure of reference zero.
// - Code 0x8B shows the guard soak timer indicator of reference zero.
// - Code 0x8C shows any unmasked signal loss, single-period, coarse frequency or guard soak indicator of reference zero.
// - Code 0x8D shows the precise frequency check failure of reference zero.
// - References one to three repeat those six codes at 0x90, 0x98, 0xA0.
// - Code 0xA8 is high only while the DPLL is in normal locking state.
// - Code 0xA9 is high while the DPLL is in holdover.
// - Codes 0xAA and 0xAB give the upper and lower selected reference bits.
// - Code 0xAD is high while DPLL frequency is beyond pull-in/hold-in limit.
// - Code 0xAF is high after phase error stayed below 36us for ten seconds.
// - Code 0xB0 is high after phase error stayed below 1us for one second.
// - Code 0xB1 is high after phase error stayed below 10us for one second.
// - Code 0xB2 is high after phase error stayed below 10us for ten seconds.
// - Code 0x00 leaves the pin a plain input with no function.
// - Code 0x60 ORs pin input with differential output zero register enable.
`default_nettype none

module gpio_function_select_mux #(
    parameter logic [31:0] P_WIN_SHORT_CYCLES = gpio_mux_pkg::LOCK_WIN_SHORT_CYCLES,
    parameter logic [31:0] P_WIN_LONG_CYCLES  = gpio_mux_pkg::LOCK_WIN_LONG_CYCLES
) (
    input  wire logic                                        i_sys_clk,
    input  wire logic                                        i_rst,
    input  wire logic                                        i_clk_en,
    input  wire logic [gpio_mux_pkg::ADDR_W-1:0]             i_avs_address,
    input  wire logic                                        i_avs_read,
    input  wire logic                                        i_avs_write,
    input  wire logic [gpio_mux_pkg::DATA_W-1:0]             i_avs_writedata,
    input  wire logic [gpio_mux_pkg::BE_W-1:0]               i_avs_byteenable,
    output var  logic [gpio_mux_pkg::DATA_W-1:0]             o_avs_readdata,
    output var  logic                                        o_avs_waitrequest,
    input  wire logic [gpio_mux_pkg::GPIO_N-1:0]             i_gpio_in,
    output var  logic [gpio_mux_pkg::GPIO_N-1:0]             o_gpio_out,
    output var  logic [gpio_mux_pkg::GPIO_N-1:0]             o_gpio_oe_n,
    input  wire logic                                        i_irq,
    input  wire gpio_mux_pkg::ref_status_s [gpio_mux_pkg::REF_N-1:0] i_ref_status,
    input  wire gpio_mux_pkg::dpll_status_s                  i_dpll_status,
    output var  logic [gpio_mux_pkg::DIFF_N-1:0]             o_fast_diff_out_en,
    output var  logic [gpio_mux_pkg::SE_N-1:0]               o_fast_single_ended_out_en
);
    import gpio_mux_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [CODE_W-1:0]       pin_cfg_reg [GPIO_N];
    logic [DIFF_N-1:0]       diff_en_reg;
    logic [SE_N-1:0]         se_en_reg;
    logic [7:0]              fail_mask_reg;
    logic [7:0]              mask_hi_reg;
    logic [REF_N*MASK_W-1:0] fail_mask;
    logic                    wait_reg;
    logic [DATA_W-1:0]       rdata_reg;
    logic [DATA_W-1:0]       rdata_next;
    logic [GPIO_N-1:0]       gpio_out_reg;
    logic [GPIO_N-1:0]       gpio_oe_n_reg;
    logic [DIFF_N-1:0]       diff_out_reg;
    logic [SE_N-1:0]         se_out_reg;

    // Per-pin decode results
    logic [GPIO_N-1:0]       pin_is_status;
    logic [GPIO_N-1:0]       pin_status_val;
    logic [DIFF_N-1:0]       diff_pin_req [GPIO_N];
    logic [SE_N-1:0]         se_pin_req   [GPIO_N];
    logic [DIFF_N-1:0]       diff_en_next;
    logic [SE_N-1:0]         se_en_next;

    // Lock qualifiers
    logic [QUAL_N-1:0]       lock_flag;
    logic [QUAL_N-1:0]       lock_ok;
    logic [CNT_W-1:0]        lock_win [QUAL_N];

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic                    bus_req;
    logic                    bus_take;
    logic                    wr_commit;
    logic                    addr_is_cfg;
    logic [1:0]              cfg_idx;
    logic                    wait_next;

    // One wait state: request seen with waitrequest high, answered next cycle
    assign bus_req     = i_avs_read | i_avs_write;
    assign bus_take    = bus_req & wait_reg;
    assign wr_commit   = i_avs_write & ~wait_reg;
    assign wait_next   = ~bus_take;
    assign addr_is_cfg = (i_avs_address >= REG_PIN_CFG_BASE) && (i_avs_address <= REG_PIN_CFG_LAST)
                         && (i_avs_address[1:0] == 2'b00);
    assign cfg_idx     = i_avs_address[3:2];

    // Read mux, captured while the request waits so data stands at the answer
    always_comb begin
        rdata_next = '0;
        if (addr_is_cfg) begin
            rdata_next[CODE_W-1:0] = pin_cfg_reg[cfg_idx];
        end else if (i_avs_address == REG_DIFF_EN) begin
            rdata_next[DIFF_N-1:0] = diff_en_reg;
        end else if (i_avs_address == REG_SE_EN) begin
            rdata_next[SE_N-1:0] = se_en_reg;
        end else if (i_avs_address == REG_FAIL_MASK) begin
            rdata_next[REF_N*MASK_W-1:0] = fail_mask;
        end else if (i_avs_address == REG_EN_STATUS) begin
            rdata_next[DIFF_N+SE_N-1:0] = {se_out_reg, diff_out_reg};
        end else if (i_avs_address == REG_PIN_STATUS) begin
            rdata_next[3*GPIO_N-1:0] = {gpio_oe_n_reg, gpio_out_reg, i_gpio_in};
        end
    end

    // Bus handshake and read data
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wait_reg  <= 1'b1;
            rdata_reg <= '0;
        end else if (i_clk_en) begin
            wait_reg <= wait_next;
            if (bus_take && i_avs_read) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Writes land at the edge where waitrequest is seen low
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            for (int i = 0; i < GPIO_N; i++) begin
                pin_cfg_reg[i] <= RST_PIN_CFG;
            end
            diff_en_reg   <= RST_DIFF_EN;
            se_en_reg     <= RST_SE_EN;
            fail_mask_reg <= RST_FAIL_MASK[7:0];
        end else if (i_clk_en && wr_commit && i_avs_byteenable[0]) begin
            if (addr_is_cfg) begin
                pin_cfg_reg[cfg_idx] <= i_avs_writedata[CODE_W-1:0];
            end else if (i_avs_address == REG_DIFF_EN) begin
                diff_en_reg <= i_avs_writedata[DIFF_N-1:0];
            end else if (i_avs_address == REG_SE_EN) begin
                se_en_reg <= i_avs_writedata[SE_N-1:0];
            end else if (i_avs_address == REG_FAIL_MASK) begin
                fail_mask_reg <= i_avs_writedata[7:0];
            end
        end
    end

    // Upper mask lane handled apart so byte enables stay independent
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mask_hi_reg <= RST_FAIL_MASK[15:8];
        end else if (i_clk_en && wr_commit && i_avs_byteenable[1] && (i_avs_address == REG_FAIL_MASK)) begin
            mask_hi_reg <= i_avs_writedata[15:8];
        end
    end

    assign fail_mask = {mask_hi_reg, fail_mask_reg};

    // ------------------------------------------------------------------
    // Lock qualification
    // ------------------------------------------------------------------
    // Phase comparator level per qualifier and its observation window
    assign lock_flag[0] = i_dpll_status.phase_err_lt_36us;
    assign lock_flag[1] = i_dpll_status.phase_err_lt_1us;
    assign lock_flag[2] = i_dpll_status.phase_err_lt_10us;
    assign lock_flag[3] = i_dpll_status.phase_err_lt_10us;
    assign lock_win[0]  = P_WIN_LONG_CYCLES;
    assign lock_win[1]  = P_WIN_SHORT_CYCLES;
    assign lock_win[2]  = P_WIN_SHORT_CYCLES;
    assign lock_win[3]  = P_WIN_LONG_CYCLES;

    generate
        for (genvar q = 0; q < QUAL_N; q++) begin : g_lock
            logic [CNT_W-1:0] cnt_reg;
            logic [CNT_W-1:0] cnt_next;

            // Any excursion restarts the window; count saturates at the window
            assign cnt_next   = !lock_flag[q]            ? '0 :
                                (cnt_reg >= lock_win[q]) ? cnt_reg :
                                cnt_reg + 1'b1;
            assign lock_ok[q] = lock_flag[q] && (cnt_reg >= lock_win[q]);

            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    cnt_reg <= '0;
                end else if (i_clk_en) begin
                    cnt_reg <= cnt_next;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Per-pin function decode
    // ------------------------------------------------------------------
    generate
        for (genvar g = 0; g < GPIO_N; g++) begin : g_pin
            logic [CODE_W-1:0] code;
            logic [4:0]        ref_blk;
            logic [1:0]        ref_idx;
            logic [2:0]        ref_fn;
            logic              ref_hit;
            logic              ref_val;
            logic              ref_fail;
            logic              dpll_hit;
            logic              dpll_val;
            ref_status_s       rs;
            logic [MASK_W-1:0] rmask;

            assign code    = pin_cfg_reg[g];
            assign ref_blk = code[7:3] - REF_BLK_BASE;
            assign ref_idx = ref_blk[1:0];
            assign ref_fn  = code[2:0];
            // Four blocks of eight codes, six used in each
            assign ref_hit = (code[7:3] >= REF_BLK_BASE) && (ref_blk < 5'(REF_N))
                             && (ref_fn <= REF_FN_PFM);
            assign rs      = i_ref_status[ref_idx];
            assign rmask   = fail_mask[ref_idx*MASK_W +: MASK_W];

            // Failure summary only counts indicators whose mask bit is one
            assign ref_fail = (rs.signal_loss_input   & rmask[MASK_LOS])
                            | (rs.single_period_check & rmask[MASK_SCM])
                            | (rs.coarse_freq_check   & rmask[MASK_CFM])
                            | (rs.guard_soak_timer    & rmask[MASK_GST]);

            assign ref_val = (ref_fn == REF_FN_NO_ACT) ? rs.no_activity :
                             (ref_fn == REF_FN_SCM)    ? rs.single_period_check :
                             (ref_fn == REF_FN_CFM)    ? rs.coarse_freq_check :
                             (ref_fn == REF_FN_GST)    ? rs.guard_soak_timer :
                             (ref_fn == REF_FN_FAIL)   ? ref_fail :
                             rs.precise_freq_check;

            assign dpll_hit = (code == CODE_NORMAL)     || (code == CODE_HOLDOVER)
                           || (code == CODE_REF_SEL_B1) || (code == CODE_REF_SEL_B0)
                           || (code == CODE_OUT_RANGE)  || (code == CODE_LOCK0)
                           || (code == CODE_LOCK1)      || (code == CODE_LOCK2)
                           || (code == CODE_LOCK3);

            assign dpll_val = (code == CODE_NORMAL)     ? (i_dpll_status.state == DPLL_NORMAL) :
                              (code == CODE_HOLDOVER)   ? (i_dpll_status.state == DPLL_HOLDOVER) :
                              (code == CODE_REF_SEL_B1) ? i_dpll_status.ref_sel[1] :
                              (code == CODE_REF_SEL_B0) ? i_dpll_status.ref_sel[0] :
                              (code == CODE_OUT_RANGE)  ? i_dpll_status.out_of_range :
                              (code == CODE_LOCK0)      ? lock_ok[0] :
                              (code == CODE_LOCK1)      ? lock_ok[1] :
                              (code == CODE_LOCK2)      ? lock_ok[2] :
                              (code == CODE_LOCK3)      ? lock_ok[3] :
                              1'b0;

            // Anything else, default code included, keeps the pin an input
            assign pin_is_status[g]  = (code == CODE_IRQ) || ref_hit || dpll_hit;
            assign pin_status_val[g] = (code == CODE_IRQ) ? i_irq :
                                       ref_hit            ? ref_val :
                                       dpll_val;

            // Control use: input ORed into the matching output enable
            for (genvar k = 0; k < DIFF_N; k++) begin : g_diff
                assign diff_pin_req[g][k] = i_gpio_in[g]
                    && (code == CODE_W'(CODE_DIFF_BASE + CODE_EN_STRIDE * k));
            end
            for (genvar k = 0; k < SE_N; k++) begin : g_se
                assign se_pin_req[g][k] = i_gpio_in[g]
                    && (code == CODE_W'(CODE_SE_BASE + CODE_EN_STRIDE * k));
            end
        end
    endgenerate

    // Several pins may claim one enable; any of them or the register bit wins
    always_comb begin
        diff_en_next = diff_en_reg;
        se_en_next   = se_en_reg;
        for (int i = 0; i < GPIO_N; i++) begin
            diff_en_next = diff_en_next | diff_pin_req[i];
            se_en_next   = se_en_next | se_pin_req[i];
        end
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    // Status pins follow their condition every cycle with i_clk_en high, no latching
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            gpio_out_reg  <= '0;
            gpio_oe_n_reg <= '1;
            diff_out_reg  <= RST_DIFF_EN;
            se_out_reg    <= RST_SE_EN;
        end else if (i_clk_en) begin
            gpio_out_reg  <= pin_is_status & pin_status_val;
            gpio_oe_n_reg <= ~pin_is_status;
            diff_out_reg  <= diff_en_next;
            se_out_reg    <= se_en_next;
        end
    end

    assign o_avs_readdata             = rdata_reg;
    assign o_avs_waitrequest          = wait_reg;
    assign o_gpio_out                 = gpio_out_reg;
    assign o_gpio_oe_n                = gpio_oe_n_reg;
    assign o_fast_diff_out_en         = diff_out_reg;
    assign o_fast_single_ended_out_en = se_out_reg;

endmodule

`default_nettype wire

// file: rtl/gpio_mux_pkg.sv
`default_nettype none

package gpio_mux_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int GPIO_N    = 4;
    localparam int DIFF_N    = 8;
    localparam int SE_N      = 4;
    localparam int REF_N     = 4;
    localparam int CODE_W    = 8;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int BE_W      = 4;
    localparam int MASK_W    = 4;
    localparam int CNT_W     = 32;
    localparam int QUAL_N    = 4;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_PIN_CFG_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PIN_CFG_LAST = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_DIFF_EN      = 8'h10;
    localparam logic [ADDR_W-1:0] REG_SE_EN        = 8'h14;
    localparam logic [ADDR_W-1:0] REG_FAIL_MASK    = 8'h18;
    localparam logic [ADDR_W-1:0] REG_EN_STATUS    = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_PIN_STATUS   = 8'h20;
    // Reset values
    localparam logic [CODE_W-1:0]         RST_PIN_CFG   = 8'h00;
    localparam logic [DIFF_N-1:0]         RST_DIFF_EN   = 8'h00;
    localparam logic [SE_N-1:0]           RST_SE_EN     = 4'h0;
    localparam logic [REF_N*MASK_W-1:0]   RST_FAIL_MASK = 16'hFFFF;
    // Failure mask field positions inside one reference nibble
    localparam int MASK_LOS = 0;
    localparam int MASK_SCM = 1;
    localparam int MASK_CFM = 2;
    localparam int MASK_GST = 3;

    // ------------------------------------------------------------------
    // Function codes
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_DEFAULT    = 8'h00;
    localparam logic [CODE_W-1:0] CODE_DIFF_BASE  = 8'h60;
    localparam logic [CODE_W-1:0] CODE_SE_BASE    = 8'h70;
    localparam int                CODE_EN_STRIDE  = 2;
    localparam logic [CODE_W-1:0] CODE_IRQ        = 8'h80;
    localparam logic [4:0]        REF_BLK_BASE    = 5'h11;   // 0x88 >> 3
    localparam logic [2:0]        REF_FN_NO_ACT   = 3'h0;
    localparam logic [2:0]        REF_FN_SCM      = 3'h1;
    localparam logic [2:0]        REF_FN_CFM      = 3'h2;
    localparam logic [2:0]        REF_FN_GST      = 3'h3;
    localparam logic [2:0]        REF_FN_FAIL     = 3'h4;
    localparam logic [2:0]        REF_FN_PFM      = 3'h5;
    localparam logic [CODE_W-1:0] CODE_NORMAL     = 8'hA8;
    localparam logic [CODE_W-1:0] CODE_HOLDOVER   = 8'hA9;
    localparam logic [CODE_W-1:0] CODE_REF_SEL_B1 = 8'hAA;
    localparam logic [CODE_W-1:0] CODE_REF_SEL_B0 = 8'hAB;
    localparam logic [CODE_W-1:0] CODE_OUT_RANGE  = 8'hAD;
    localparam logic [CODE_W-1:0] CODE_LOCK0      = 8'hAF;
    localparam logic [CODE_W-1:0] CODE_LOCK1      = 8'hB0;
    localparam logic [CODE_W-1:0] CODE_LOCK2      = 8'hB1;
    localparam logic [CODE_W-1:0] CODE_LOCK3      = 8'hB2;

    // ------------------------------------------------------------------
    // Timing: lock observation windows
    // ------------------------------------------------------------------
    localparam longint CLK_HZ              = 40_000_000;
    localparam longint LOCK_WIN_SHORT_S    = 1;
    localparam longint LOCK_WIN_LONG_S     = 10;
    localparam logic [CNT_W-1:0] LOCK_WIN_SHORT_CYCLES = CNT_W'(LOCK_WIN_SHORT_S * CLK_HZ);
    localparam logic [CNT_W-1:0] LOCK_WIN_LONG_CYCLES  = CNT_W'(LOCK_WIN_LONG_S * CLK_HZ);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {DPLL_FREERUN, DPLL_NORMAL, DPLL_HOLDOVER} dpll_state_e;
    typedef struct packed {
        logic signal_loss_input;
        logic no_activity;
        logic single_period_check;
        logic coarse_freq_check;
        logic guard_soak_timer;
        logic precise_freq_check;
    } ref_status_s;

    typedef struct packed {
        dpll_state_e state;
        logic [1:0]  ref_sel;
        logic        out_of_range;
        logic        phase_err_lt_1us;
        logic        phase_err_lt_10us;
        logic        phase_err_lt_36us;
    } dpll_status_s;

endpackage

`default_nettype wire

// file: test/board_pins_model.sv
`default_nettype none
// ----------------------------------------
// Board side of the pins
// ----------------------------------------
module board_pins_model (
    input  wire logic [gpio_mux_pkg::GPIO_N-1:0] i_drive,
    input  wire logic [gpio_mux_pkg::GPIO_N-1:0] i_oe_n,
    input  wire logic [gpio_mux_pkg::GPIO_N-1:0] i_out,
    output var  logic [gpio_mux_pkg::GPIO_N-1:0] o_level
);
    timeunit 1ns;
    timeprecision 100ps;
    // Board only drives a pin the device leaves alone, so no contention
    assign o_level = (i_drive & i_oe_n) | (i_out & ~i_oe_n);
endmodule
`default_nettype wire

// file: test/gpio_mux_chk.sv
`default_nettype none
// ----------------------------------------
// Port checks
// ----------------------------------------
module gpio_mux_chk (
    input wire logic                              i_sys_clk,
    input wire logic                              i_rst,
    input wire logic                              i_clk_en,
    input wire logic                              i_avs_read,
    input wire logic                              i_avs_write,
    input wire logic [gpio_mux_pkg::GPIO_N-1:0] i_gpio_in,
    input wire logic                              o_avs_waitrequest,
    input wire logic [gpio_mux_pkg::GPIO_N-1:0] o_gpio_out,
    input wire logic [gpio_mux_pkg::GPIO_N-1:0] o_gpio_oe_n,
    input wire logic [gpio_mux_pkg::DIFF_N-1:0] o_fast_diff_out_en,
    input wire logic [gpio_mux_pkg::SE_N-1:0]   o_fast_single_ended_out_en
);
    import gpio_mux_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Bus answers once per request, one cycle late
    property p_answer; i_clk_en && (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_wait_one; i_clk_en && !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer held too long");
    property p_idle; o_avs_waitrequest && !i_avs_read && !i_avs_write |=> o_avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    // Reset leaves every pin an undriven input
    property p_rst_pins; $fell(i_rst) |-> o_gpio_oe_n == 4'hF && o_gpio_out == 4'h0; endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins driven after reset");
    property p_rst_en; $fell(i_rst) |-> o_fast_diff_out_en == 8'h00 && o_fast_single_ended_out_en == 4'h0; endproperty
    a_rst_en: assert property (p_rst_en) else $error("enables set after reset");
    property p_undriven; (o_gpio_out & o_gpio_oe_n) == 4'h0; endproperty
    a_undriven: assert property (p_undriven) else $error("undriven pin shows high");
    // Drive changes only after reset or a write; enables also after a pin input change
    property p_oe_cause; $changed(o_gpio_oe_n) |-> $past(i_rst) || $past(i_avs_write, 2) || $past(i_avs_write, 3);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin drive changed unprompted");
    property p_en_cause; $changed({o_fast_single_ended_out_en, o_fast_diff_out_en}) |-> $past(i_rst)
        || $past(i_avs_write, 2) || $past(i_avs_write, 3) || $past(i_gpio_in) != $past(i_gpio_in, 2); endproperty
    a_en_cause: assert property (p_en_cause) else $error("enable changed unprompted");
endmodule
bind gpio_function_select_mux gpio_mux_chk gpio_mux_chk_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_gpio_in(i_gpio_in), .o_avs_waitrequest(o_avs_waitrequest),
    .o_gpio_out(o_gpio_out), .o_gpio_oe_n(o_gpio_oe_n), .o_fast_diff_out_en(o_fast_diff_out_en),
    .o_fast_single_ended_out_en(o_fast_single_ended_out_en));
`default_nettype wire

// file: test/gpio_function_select_mux_bench.sv
`default_nettype none
`define CHK(nm, e, g) comparisons++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %0h got %0h", nm, e, g); end
module gpio_function_select_mux_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import gpio_mux_pkg::*;
    logic clk = 1'b0, rst = 1'b1, en = 1'b1, rd_en = 1'b0, wr_en = 1'b0, irq = 1'b0, wait_req;
    logic [7:0] addr = 8'h00, c, diff_en;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] drive = 4'h0, pin_in, pin_out, pin_oe_n, se_en;
    logic [5:0] p;
    ref_status_s [REF_N-1:0] refs = '0, tmp;
    dpll_status_s dpll = '0;
    int fails = 0, comparisons = 0, cyc = 0, w;
    // Short lock windows keep the run brief
    gpio_function_select_mux #(.P_WIN_SHORT_CYCLES(32'hA), .P_WIN_LONG_CYCLES(32'h1E)) gpio_function_select_mux_i (
        .i_sys_clk(clk), .i_rst(rst), .i_clk_en(en), .i_avs_address(addr), .i_avs_read(rd_en),
        .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req), .i_gpio_in(pin_in), .o_gpio_out(pin_out), .o_gpio_oe_n(pin_oe_n), .i_irq(irq),
        .i_ref_status(refs), .i_dpll_status(dpll), .o_fast_diff_out_en(diff_en), .o_fast_single_ended_out_en(se_en));
    board_pins_model board_pins_model_i (.i_drive(drive), .i_oe_n(pin_oe_n), .i_out(pin_out), .o_level(pin_in));
    always #12.5 clk = ~clk;
    // Watchdog against a hung handshake
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    // Bus cycles hold until waitrequest is seen low
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a; wdata <= d; wr_en <= 1'b1;
        do @(posedge clk); while (wait_req !== 1'b0);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        addr <= a; rd_en <= 1'b1;
        do @(posedge clk); while (wait_req !== 1'b0);
        `CHK("readdata", e, rdata)
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic look(input int n, input logic eo, input logic en);
        repeat (3) @(posedge clk);
        `CHK("pin_out", eo, pin_out[n])
        `CHK("pin_oe_n", en, pin_oe_n[n])
    endtask
    task automatic dp(input logic [7:0] cd, input logic [7:0] v, input logic e);
        wr(8'h0C, {24'h0, cd});
        dpll <= v;
        look(3, e, 1'b0);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(REG_FAIL_MASK, 32'h0000FFFF);
        rd(8'h40, 32'h0);
        look(0, 1'b0, 1'b1);
        wr(8'h00, 32'h81);
        look(0, 1'b0, 1'b1);
        wr(8'h00, 32'h80);
        irq <= 1'b1; en <= 1'b0;
        look(0, 1'b0, 1'b0);
        en <= 1'b1;
        look(0, 1'b1, 1'b0);
        irq <= 1'b0;
        look(0, 1'b0, 1'b0);
        $display("test defaults and interrupt done");
        for (int k = 0; k < 6; k++) begin
            c = (k == 0) ? 8'h60 : (k == 1) ? 8'h6E : 8'h70 + 8'(2 * (k - 2));
            wr(8'h04, {24'h0, c});
            drive <= 4'h2;
            repeat (3) @(posedge clk);
            `CHK("enables", (k < 2) ? {4'h0, 8'(1 << (c[3:0] / 2))} : {4'(1 << (k - 2)), 8'h00}, {se_en, diff_en})
            drive <= 4'h0;
            repeat (3) @(posedge clk);
            `CHK("enables", 12'h000, {se_en, diff_en})
        end
        wr(REG_SE_EN, 32'h1);
        rd(REG_EN_STATUS, 32'h100);
        `CHK("se_en", 4'h1, se_en)
        $display("test control codes done");
        for (int r = 0; r < 4; r++) begin
            for (int f = 0; f < 6; f++) begin
                p = 6'(1 << ((f == 4) ? 5 : (f > 4) ? 0 : 4 - f));
                wr(8'h08, {24'h0, 8'h88 + 8'(8 * r + f)});
                tmp = '0; tmp[r] = ref_status_s'(p); refs <= tmp;
                look(2, 1'b1, 1'b0);
                tmp = '1; tmp[r] = ref_status_s'((f == 4) ? 6'h11 : ~p); refs <= tmp;
                look(2, 1'b0, 1'b0);
            end
        end
        wr(REG_FAIL_MASK, 32'h00FE);
        rd(REG_FAIL_MASK, 32'h000000FE);
        wr(8'h08, 32'h8C);
        tmp = '0; tmp[0] = ref_status_s'(6'h20); refs <= tmp;
        look(2, 1'b0, 1'b0);
        tmp[0] = ref_status_s'(6'h08); refs <= tmp;
        look(2, 1'b1, 1'b0);
        $display("test reference status done");
        dp(8'hA8, {DPLL_NORMAL, 6'h00}, 1'b1);
        dp(8'hA8, {DPLL_HOLDOVER, 6'h00}, 1'b0);
        dp(8'hA8, {DPLL_FREERUN, 6'h00}, 1'b0);
        dp(8'hA9, {DPLL_HOLDOVER, 6'h00}, 1'b1);
        dp(8'hA9, {DPLL_NORMAL, 6'h00}, 1'b0);
        dp(8'hAA, {DPLL_FREERUN, 6'h20}, 1'b1);
        dp(8'hAA, {DPLL_FREERUN, 6'h10}, 1'b0);
        dp(8'hAB, {DPLL_FREERUN, 6'h10}, 1'b1);
        dp(8'hAB, {DPLL_FREERUN, 6'h20}, 1'b0);
        dp(8'hAD, {DPLL_NORMAL, 6'h08}, 1'b1);
        dp(8'hAD, {DPLL_NORMAL, 6'h00}, 1'b0);
        for (int k = 0; k < 4; k++) begin
            w = (k == 0 || k == 3) ? 30 : 10;
            dp(8'hAF + 8'(k), 8'h00, 1'b0);
            dpll <= {DPLL_NORMAL, 3'b000, k == 1, k >= 2, k == 0};
            repeat (w + 1) @(posedge clk);
            `CHK("lock_early", 1'b0, pin_out[3])
            repeat (1) @(posedge clk);
            `CHK("lock_set", 1'b1, pin_out[3])
        end
        dp(8'hB2, 8'h00, 1'b0);
        $display("test dpll status done");
        wrap_up();
    end
endmodule
`default_nettype wire
